// File: design/bio_options.sv
// Bus information options register with its APB slave port.
// Assumes an APB3 master on pclk, a global reset that the system drives
// at power-up, and node events that are one-cycle pulses on pclk.
// Notes on behaviour
// (RL1) 32-bit register at 20h, published as quadlet.
// (RL2) Software sets capability flags before link enable.
// (RL3) Bits 31..27 read/write, reset to zero.
// (RL4) Bit 27 set advertises power management capability.
// (RL5) Bits 26..24 read as zero.
// (RL6) Clock accuracy bits 23..16, read/write, reset 00h.
// (RL7) Request size is two to exponent plus one.
// (RL8) Software keeps exponent valid while link enabled.
// (RL9) Oversized block write may raise type error.
// (RL10) Software reset keeps exponent; hardware reset loads Ah.
// (RL11) Exponent reset only by the global reset.
// (RL12) Generation count bumps after ROM change, bus reset.
// (RL13) Speed bits read constant 010.
// (RL14) Bits 11..8 read as zero.
// (RL15) Writes touch only read/write fields.
`timescale 1ns/10ps
module bio_options (
    // Clock, resets and enable.
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        global_reset_n,
    input  wire logic                        pclk_en,
    // APB slave.
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [bio_pkg::BIO_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Node events.
    input  wire logic                        soft_reset,
    input  wire logic                        bus_reset,
    input  wire logic                        rom_changed,
    input  wire logic                        rx_wr_valid,
    input  wire logic [bio_pkg::BIO_LEN_W-1:0] rx_wr_len,
    // Published values.
    output logic      [31:0]                 bus_info_quadlet,
    output logic                             ack_type_error
);
    import bio_pkg::*;

    bio_chk_if chk_link ();

    // Read/write fields.
    logic [4:0] flags;
    logic [7:0] clk_acc;
    logic [1:0] gen_count;
    logic       rom_dirty;
    logic [3:0] max_req;
    logic [4:0] next_flags;
    logic [7:0] next_clk_acc;
    logic [1:0] next_gen_count;
    logic       next_rom_dirty;
    logic [3:0] next_max_req;

    // Bus response state.
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_quadlet;

    logic        access;
    logic        hit;
    logic        wr_hit;
    logic        bump;
    bio_word_t   cur_word;

    always_comb begin
        access = psel && penable;
        hit    = (paddr == BIO_OFF_OPTIONS);
        // A write lands on the edge at which pready is seen high.
        wr_hit = access && pready && pwrite && hit;
        bump   = bus_reset && rom_dirty;
    end

    // Assemble the quadlet; reserved bits are tied to zero.
    always_comb begin
        cur_word = '0;                                        // [RL5] [RL14]
        cur_word[BIO_FLAG_HI:BIO_FLAG_LO] = flags;            // [RL3] [RL4]
        cur_word[BIO_ACC_HI:BIO_ACC_LO]   = clk_acc;          // [RL6]
        cur_word[BIO_MREQ_HI:BIO_MREQ_LO] = max_req;          // [RL7]
        cur_word[BIO_GEN_HI:BIO_GEN_LO]   = gen_count;        // [RL12]
        cur_word[BIO_SPD_HI:BIO_SPD_LO]   = BIO_SPD_VAL;      // [RL13]
    end

    // Next values of the fields reset by presetn or a software reset.
    always_comb begin
        next_flags     = flags;
        next_clk_acc   = clk_acc;
        next_gen_count = gen_count;
        // A ROM change in the same cycle as a bus reset stays pending.
        next_rom_dirty = rom_changed || (rom_dirty && !bus_reset);
        if (bump) begin
            next_gen_count = gen_count + 2'h1;                // [RL12]
        end
        if (wr_hit) begin
            // Only read/write positions are taken from the write data.
            next_flags     = pwdata[BIO_FLAG_HI:BIO_FLAG_LO]; // [RL3] [RL15]
            next_clk_acc   = pwdata[BIO_ACC_HI:BIO_ACC_LO];   // [RL6] [RL15]
            next_gen_count = pwdata[BIO_GEN_HI:BIO_GEN_LO];   // [RL12] [RL15]
        end
        if (soft_reset) begin
            next_flags     = BIO_FLAG_RST;
            next_clk_acc   = BIO_ACC_RST;
            next_gen_count = BIO_GEN_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags     <= BIO_FLAG_RST;                        // [RL3]
            clk_acc   <= BIO_ACC_RST;                         // [RL6]
            gen_count <= BIO_GEN_RST;
            rom_dirty <= 1'b0;
        end else if (pclk_en) begin
            flags     <= next_flags;
            clk_acc   <= next_clk_acc;
            gen_count <= next_gen_count;
            rom_dirty <= next_rom_dirty;
        end
    end

    // The exponent ignores the software reset and presetn.
    always_comb begin
        next_max_req = max_req;                               // [RL10]
        if (wr_hit) begin
            next_max_req = pwdata[BIO_MREQ_HI:BIO_MREQ_LO];   // [RL15]
        end
    end

    always_ff @(posedge pclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            max_req <= BIO_MREQ_RST;                          // [RL10] [RL11]
        end else if (pclk_en) begin
            max_req <= next_max_req;
        end
    end

    // APB answer: one wait state, error on any unmapped address.
    always_comb begin
        next_pready  = access && !pready;
        next_pslverr = access && !pready && !hit;
        next_prdata  = prdata;
        if (access && !pready) begin
            next_prdata = hit ? cur_word : 32'h00000000;      // [RL5] [RL14]
        end
        next_quadlet = cur_word;                              // [RL1]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            prdata           <= 32'h00000000;
            bus_info_quadlet <= {BIO_FLAG_RST, 3'h0, BIO_ACC_RST,
                                 BIO_MREQ_RST, 4'h0, BIO_GEN_RST,
                                 3'h0, BIO_SPD_VAL};
        end else if (pclk_en) begin
            pready           <= next_pready;
            pslverr          <= next_pslverr;
            prdata           <= next_prdata;
            bus_info_quadlet <= next_quadlet;                 // [RL1]
        end
    end

    assign chk_link.max_req  = max_req;
    assign chk_link.rx_valid = rx_wr_valid;
    assign chk_link.rx_len   = rx_wr_len;

    bio_req_check u_req_check (
        .pclk    (pclk),
        .presetn (presetn),
        .pclk_en (pclk_en),
        .chk     (chk_link.chk)
    );

    assign ack_type_error = chk_link.too_long;                // [RL9]

    // Checks on the register behaviour.
    quad_mirror_a: assert property ( // [RL1]
        @(posedge pclk) disable iff (!presetn)
        pclk_en |=> bus_info_quadlet == $past(cur_word))
        else $error("published quadlet differs from register");

    flag_write_a: assert property ( // [RL3]
        @(posedge pclk) disable iff (!presetn)
        pclk_en && wr_hit && !soft_reset
        |=> flags == $past(pwdata[31:27]))
        else $error("capability flags not written");

    pmc_publish_a: assert property ( // [RL4]
        @(posedge pclk) disable iff (!presetn)
        pclk_en && flags[0] |=> bus_info_quadlet[BIO_PMC_BIT])
        else $error("power management flag not published");

    rsvd_zero_a: assert property ( // [RL5]
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[26:24] == 3'h0 && prdata[5:3] == 3'h0)
        else $error("upper reserved bits read nonzero");

    rsvd_low_a: assert property ( // [RL14]
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[11:8] == 4'h0)
        else $error("bits 11 to 8 read nonzero");

    acc_write_a: assert property ( // [RL6]
        @(posedge pclk) disable iff (!presetn)
        pclk_en && wr_hit && !soft_reset
        |=> clk_acc == $past(pwdata[23:16]))
        else $error("clock accuracy not written");

    mreq_soft_a: assert property ( // [RL10]
        @(posedge pclk) disable iff (!presetn || !global_reset_n)
        soft_reset && !wr_hit |=> $stable(max_req))
        else $error("software reset changed exponent");

    mreq_global_reset_n_a: assert property ( // [RL11]
        @(posedge pclk) disable iff (!presetn)
        !global_reset_n |-> max_req == 4'ha)
        else $error("global reset did not load exponent");

    speed_const_a: assert property ( // [RL13]
        @(posedge pclk) disable iff (!presetn)
        bus_info_quadlet[2:0] == 3'b010 && (!pready || !hit
        || prdata[2:0] == 3'b010))
        else $error("speed code is not 010");

    gen_bump_a: assert property ( // [RL12]
        @(posedge pclk) disable iff (!presetn)
        pclk_en && bump && !wr_hit && !soft_reset
        |=> gen_count == $past(gen_count) + 2'h1)
        else $error("generation count did not advance");

    ro_ignore_a: assert property ( // [RL15]
        @(posedge pclk) disable iff (!presetn)
        pclk_en && wr_hit |=> ##1 bus_info_quadlet[26:24] == 3'h0
        && bus_info_quadlet[11:8] == 4'h0)
        else $error("write reached a read-only bit");

    bad_addr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pclk_en && access && !pready && !hit |=> pready && pslverr)
        else $error("unmapped access not refused");

    write_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr_hit);
    read_c: cover property (@(posedge pclk) disable iff (!presetn)
        access && pready && !pwrite && hit);
    gen_c: cover property (@(posedge pclk) disable iff (!presetn)
        pclk_en && bump);
    soft_c: cover property (@(posedge pclk) disable iff (!presetn)
        soft_reset && max_req != BIO_MREQ_RST);

endmodule : bio_options

// File: design/bio_req_check.sv
// Flags a received block write whose payload exceeds the largest
// supported block request size.
// Assumes requests arrive as one-cycle pulses on the pclk domain.
`timescale 1ns/10ps
module bio_req_check (
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    // Link to the options register.
    bio_chk_if.chk   chk
);
    import bio_pkg::*;

    logic [16:0] limit_bytes;
    logic        too_long;
    logic        next_too_long;

    // Size in bytes is two to the power of the exponent plus one.
    always_comb begin
        limit_bytes   = 17'h00001 << (5'(chk.max_req) + 5'h01); // [RL7]
        next_too_long = chk.rx_valid
                        && ({1'b0, chk.rx_len} > limit_bytes); // [RL9]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            too_long <= 1'b0;
        end else if (pclk_en) begin
            too_long <= next_too_long;
        end
    end

    assign chk.too_long = too_long;

    too_long_a: assert property (@(posedge pclk) disable iff (!presetn)
        pclk_en && chk.rx_valid && (chk.rx_len > 16'(limit_bytes))
        && !limit_bytes[16] |=> too_long) // [RL9]
        else $error("oversized write not flagged");

    short_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        pclk_en && chk.rx_valid && ({1'b0, chk.rx_len} <= limit_bytes)
        |=> !too_long) // [RL7]
        else $error("write within limit flagged");

    too_long_c: cover property (@(posedge pclk) disable iff (!presetn)
        pclk_en && chk.rx_valid ##1 too_long);

endmodule : bio_req_check

// File: shared/bio_chk_if.sv
// Carries the request-size limit and received write lengths between the
// options register and the payload length checker.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface bio_chk_if;
    import bio_pkg::*;

    logic [3:0]           max_req;
    logic                 rx_valid;
    logic [BIO_LEN_W-1:0] rx_len;
    logic                 too_long;

    modport regs (output max_req, output rx_valid, output rx_len,
                  input too_long);
    modport chk  (input max_req, input rx_valid, input rx_len,
                  output too_long);
endinterface : bio_chk_if

// File: shared/bio_pkg.sv
// Constants for the bus information options register block.
// Assumes a 32-bit APB register bus with byte addresses on paddr.
package bio_pkg;

    // Address map.
    localparam int          BIO_ADDR_W      = 12;
    localparam logic [11:0] BIO_OFF_OPTIONS = 12'h020;

    // Field positions inside the options quadlet.
    localparam int BIO_FLAG_HI = 31;
    localparam int BIO_FLAG_LO = 27;
    localparam int BIO_PMC_BIT = 27;
    localparam int BIO_RSA_HI  = 26;
    localparam int BIO_RSA_LO  = 24;
    localparam int BIO_ACC_HI  = 23;
    localparam int BIO_ACC_LO  = 16;
    localparam int BIO_MREQ_HI = 15;
    localparam int BIO_MREQ_LO = 12;
    localparam int BIO_RSB_HI  = 11;
    localparam int BIO_RSB_LO  = 8;
    localparam int BIO_GEN_HI  = 7;
    localparam int BIO_GEN_LO  = 6;
    localparam int BIO_RSC_HI  = 5;
    localparam int BIO_RSC_LO  = 3;
    localparam int BIO_SPD_HI  = 2;
    localparam int BIO_SPD_LO  = 0;

    // Reset and constant field values.
    localparam logic [4:0] BIO_FLAG_RST = 5'h00;
    localparam logic [7:0] BIO_ACC_RST  = 8'h00;
    localparam logic [3:0] BIO_MREQ_RST = 4'ha;
    localparam logic [1:0] BIO_GEN_RST  = 2'h0;
    localparam logic [2:0] BIO_SPD_VAL  = 3'h2;
    localparam logic [3:0] BIO_MREQ_MIN = 4'h8;

    // Width of a received payload length.
    localparam int BIO_LEN_W = 16;

    typedef logic [31:0] bio_word_t;

endpackage : bio_pkg

// File: tb/bio_options_bench.sv
// Self-checking bench for the bus information options register.
// Assumes bio_options with its APB port and the bio_pkg constants.
`timescale 1ns/10ps
module bio_options_bench;
    import bio_pkg::*;

    logic                  pclk;
    logic                  presetn;
    logic                  global_reset_n;
    logic                  pclk_en;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [BIO_ADDR_W-1:0] paddr;
    bio_word_t             pwdata;
    bio_word_t             prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  soft_reset;
    logic                  bus_reset;
    logic                  rom_changed;
    logic                  rx_wr_valid;
    logic [BIO_LEN_W-1:0]  rx_wr_len;
    bio_word_t             bus_info_quadlet;
    logic                  ack_type_error;
    int                    n_mismatch;
    int                    tests_run;
    int                    cycles = 0;

    bio_options bio_options_inst (
        .pclk(pclk), .presetn(presetn), .global_reset_n(global_reset_n),
        .pclk_en(pclk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .soft_reset(soft_reset), .bus_reset(bus_reset),
        .rom_changed(rom_changed), .rx_wr_valid(rx_wr_valid),
        .rx_wr_len(rx_wr_len), .bus_info_quadlet(bus_info_quadlet),
        .ack_type_error(ack_type_error)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // A hung handshake ends the run here.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic chk_word(input string what, input bio_word_t exp,
                            input bio_word_t got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [BIO_ADDR_W-1:0] a,
                       input bio_word_t wd, output bio_word_t rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Sample at the rising edge; the design updates only after it.
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk_word("apb access cycles", 32'h0000_0002, n);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [BIO_ADDR_W-1:0] a, input bio_word_t d,
                          input logic exp_err);
        bio_word_t rd;
        logic      err;
        apb(1'b1, a, d, rd, err);
        chk_bit("pslverr", exp_err, err);
    endtask : wr_reg

    task automatic expect_reg(input bio_word_t exp);
        bio_word_t rd;
        logic      err;
        apb(1'b0, BIO_OFF_OPTIONS, 32'h0000_0000, rd, err);
        chk_bit("pslverr", 1'b0, err);
        chk_word("prdata", exp, rd);
        @(negedge pclk);
        chk_word("bus_info_quadlet", exp, bus_info_quadlet);
    endtask : expect_reg

    // Bits are soft_reset, rom_changed, bus_reset.
    task automatic pulse(input logic [2:0] w);
        @(posedge pclk);
        {soft_reset, rom_changed, bus_reset} <= w;
        @(posedge pclk);
        {soft_reset, rom_changed, bus_reset} <= 3'b000;
    endtask : pulse

    // Bits are presetn, global_reset_n while low.
    task automatic rst_pulse(input logic [1:0] w);
        @(posedge pclk);
        {presetn, global_reset_n} <= w;
        repeat (2) @(posedge pclk);
        {presetn, global_reset_n} <= 2'b11;
    endtask : rst_pulse

    task automatic t_fields();
        bio_word_t rd;
        logic      err;
        expect_reg(32'h0000_a002);
        wr_reg(BIO_OFF_OPTIONS, 32'hffff_ffff, 1'b0);
        expect_reg(32'hf8ff_f0c2);
        wr_reg(12'h024, 32'h0000_0000, 1'b1);
        apb(1'b0, 12'h024, 32'h0000_0000, rd, err);
        chk_bit("pslverr", 1'b1, err);
        chk_word("prdata", 32'h0000_0000, rd);
        expect_reg(32'hf8ff_f0c2);
    endtask : t_fields

    task automatic t_events();
        // A software reset while the clock enable is low must not land.
        @(posedge pclk);
        pclk_en <= 1'b0;
        pulse(3'b100);
        pclk_en <= 1'b1;
        expect_reg(32'hf8ff_f0c2);
        pulse(3'b100);
        expect_reg(32'h0000_f002);
        pulse(3'b001);
        expect_reg(32'h0000_f002);
        pulse(3'b010);
        pulse(3'b001);
        expect_reg(32'h0000_f042);
        wr_reg(BIO_OFF_OPTIONS, 32'h0000_9000, 1'b0);
        rst_pulse(2'b01);
        expect_reg(32'h0000_9002);
        rst_pulse(2'b10);
        expect_reg(32'h0000_a002);
    endtask : t_events

    task automatic t_oversize(input logic [3:0] e);
        int lim;
        int hits;
        lim = 2 ** (int'(e) + 1);
        wr_reg(BIO_OFF_OPTIONS, {16'h0000, e, 12'h000}, 1'b0);
        for (int k = 0; k < 2; k++) begin
            hits = 0;
            @(posedge pclk);
            rx_wr_valid <= 1'b1;
            rx_wr_len   <= BIO_LEN_W'(lim + k);
            @(posedge pclk);
            rx_wr_valid <= 1'b0;
            repeat (4) begin
                @(negedge pclk);
                if (ack_type_error === 1'b1) hits++;
            end
            chk_word("ack_type_error pulses", k, hits);
        end
    endtask : t_oversize

    initial begin
        presetn        = 1'b0;
        global_reset_n = 1'b0;
        pclk_en        = 1'b1;
        psel           = 1'b0;
        penable        = 1'b0;
        pwrite         = 1'b0;
        paddr          = '0;
        pwdata         = '0;
        soft_reset     = 1'b0;
        bus_reset      = 1'b0;
        rom_changed    = 1'b0;
        rx_wr_valid    = 1'b0;
        rx_wr_len      = '0;
        n_mismatch     = 0;
        tests_run      = 0;
        repeat (10) @(posedge pclk);
        presetn        <= 1'b1;
        global_reset_n <= 1'b1;
        t_fields();
        t_events();
        t_oversize(BIO_MREQ_MIN);
        t_oversize(4'ha);
        give_verdict();
    end
endmodule : bio_options_bench
